//--- core/tct_pkg.sv
// Constants, register map and carrier types of the two-channel timer
// Assumes a classic Wishbone slave with 32-bit data, one register per word
// Functional notes
// (R1) Counter matching modulo rolls to zero, sets overflow
// (R2) Overflow request equals flag and enable
// (R3) Capture channel flags active pin edge
// (R4) Compare channel flags counter equal to compare
// (R5) Channel request gated by enable; reset clears
// (R6) Overflow flag clears by read then zero write
// (R7) Channel flag clears by read then zero write
// (R8) Halt bit freezes counting; set at reset
// (R9) Clear bit zeroes counter, prescaler; reads zero
// (R10) Halt plus clear leaves counter stopped at zero
// (R11) Divider select picks bus divide or external
// (R12) External clock forces shared pin to input
// (R13) High byte read latches low byte until read
// (R14) Modulo high write blocks overflow until low
// (R15) Software clears counter before new modulo
// (R16) Channel 0 buffered bit disables channel 1
// (R17) Break holds the counter stopped
// (R18) Break without clear enable protects flags
// (R19) Break with clear enable allows lasting clears
// (R20) Wait keeps counting, blocks access, wakes
// (R21) Stop halts timer, keeps all state; counting, compare matches and bus access stop, capture pin edges still set channel flags
// (R22) Toggle-on-overflow beats coincident compare match
package tct_pkg;
   localparam logic [3:0] TCT_ADR_TSCTL = 4'h0;
   localparam logic [3:0] TCT_ADR_CNTH = 4'h1;
   localparam logic [3:0] TCT_ADR_CNTL = 4'h2;
   localparam logic [3:0] TCT_ADR_MODH = 4'h3;
   localparam logic [3:0] TCT_ADR_MODL = 4'h4;
   localparam logic [3:0] TCT_ADR_CH0SC = 4'h5;
   localparam logic [3:0] TCT_ADR_CH0H = 4'h6;
   localparam logic [3:0] TCT_ADR_CH0L = 4'h7;
   localparam logic [3:0] TCT_ADR_CH1SC = 4'h8;
   localparam logic [3:0] TCT_ADR_CH1H = 4'h9;
   localparam logic [3:0] TCT_ADR_CH1L = 4'hA;
   localparam int TCT_ADR_LSB = 2;
   // Timer status/control bit positions
   localparam int TCT_B_OVF = 7;
   localparam int TCT_B_OVIE = 6;
   localparam int TCT_B_HALT = 5;
   localparam int TCT_B_CLR = 4;
   // Channel status/control bit positions
   localparam int TCT_B_CHF = 7;
   localparam int TCT_B_CHIE = 6;
   localparam int TCT_B_MSB = 5;
   localparam int TCT_B_MSA = 4;
   localparam int TCT_B_ELSB = 3;
   localparam int TCT_B_ELSA = 2;
   localparam int TCT_B_TOV = 1;
   localparam int TCT_B_MAX = 0;
   localparam logic [2:0] TCT_DIV_EXT = 3'h7;
   localparam logic [2:0] TCT_DIV_RST = 3'h0;
   localparam logic [15:0] TCT_MOD_RST = 16'hFFFF;
   localparam logic [15:0] TCT_CNT_RST = 16'h0000;
   localparam logic [5:0] TCT_PRE_RST = 6'h00;
   localparam logic [7:0] TCT_CHSC_RST = 8'h00;
   localparam logic [31:0] TCT_RD_UNMAPPED = 32'h0000_0000;
   typedef enum logic [1:0] {TCT_RUN, TCT_WAIT, TCT_STOP} tct_pwr_t;
   typedef struct packed {
      logic flag;
      logic irqEn;
      logic bufSel;
      logic modeA;
      logic edgeB;
      logic edgeA;
      logic togOvf;
      logic maxDuty;
   } tct_chsc_t;
   typedef struct packed {
      logic brk;
      logic brkClrEn;
      tct_pwr_t pwr;
   } tct_sys_t;
endpackage

//--- core/tct_timer.sv
// Two-channel 16-bit timer with modulo, prescaler and Wishbone registers
// Assumes synchronous pins on mclk; the system supplies break and power state
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tct_timer
   import tct_pkg::*;
#(
   parameter int NCH = 2
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire tct_sys_t sysState,
   input wire logic extCountClock,
   input wire logic portB3DirectionBit,
   output logic portB3OutEnable,
   input wire logic [NCH-1:0] chPinIn,
   output logic [NCH-1:0] chPinOut,
   output logic [NCH-1:0] chPinOe,
   output logic overflowIrq,
   output logic [NCH-1:0] channelIrq,
   output logic wakeReq
);
   // ==========================================================
   // Bus decode
   logic ackQ, ackD;
   logic busReq, wrEn, rdEn, lane0;
   logic [3:0] adr;
   logic brkProt;
   assign busReq = wb_cyc_i && wb_stb_i && !ackQ && sysState.pwr == TCT_RUN; // [R20]
   assign adr = wb_adr_i[TCT_ADR_LSB+3:TCT_ADR_LSB];
   assign lane0 = wb_sel_i[0];
   assign wrEn = busReq && wb_we_i && lane0;
   assign rdEn = busReq && !wb_we_i;
   assign brkProt = sysState.brk && !sysState.brkClrEn; // [R18]
   assign wb_ack_o = ackQ;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction

   // ==========================================================
   // Registers and counter state
   logic ovfQ, ovfD, ovieQ, ovieD, haltQ, haltD;
   logic [2:0] divQ, divD;
   logic [15:0] cntQ, cntD, modQ, modD;
   logic [5:0] preQ, preD;
   logic [7:0] latQ, latD;
   logic latdQ, latdD, modLockQ, modLockD, ovfArmQ, ovfArmD;
   logic extQ, extD;
   logic [31:0] rdatQ, rdatD;
   tct_chsc_t chQ [NCH], chD [NCH];
   logic [15:0] cmpQ [NCH], cmpD [NCH];
   logic [NCH-1:0] armQ, armD, pinQ, pinD, outQ, outD;
   logic tick, ovfEvt, running;
   logic [NCH-1:0] chEvt, chEn;

   // Count enable from divider select or external rising edge
   always_comb
   begin
      tick = 1'b0;
      if (divQ == TCT_DIV_EXT) // [R11]
         tick = extCountClock && !extQ;
      else if (divQ == TCT_DIV_RST)
         tick = 1'b1;
      else
         // Pulse once per 2^n cycles when the low n prescaler bits are all ones
         tick = (preQ & (6'h3F >> (3'd6 - divQ))) == (6'h3F >> (3'd6 - divQ));
   end
   assign running = !haltQ && !sysState.brk && sysState.pwr != TCT_STOP; // [R8] [R17] [R21]
   assign ovfEvt = running && tick && cntQ == modQ && !modLockQ; // [R1] [R14]
   assign chEn[0] = 1'b1;
   assign chEn[NCH-1] = !chQ[0].bufSel; // [R16]

   generate
      for (genvar i = 0; i < NCH; i++)
      begin : g_evt
         logic capMode, rise, fall;
         assign capMode = !chQ[i].bufSel && !chQ[i].modeA;
         assign rise = chPinIn[i] && !pinQ[i];
         assign fall = !chPinIn[i] && pinQ[i];
         always_comb
         begin
            chEvt[i] = 1'b0;
            if (chEn[i] && (chQ[i].edgeA || chQ[i].edgeB || !capMode))
            begin
               if (capMode)
                  chEvt[i] = (chQ[i].edgeA && rise) || (chQ[i].edgeB && fall); // [R3]
               else
                  chEvt[i] = running && tick && cntQ == cmpQ[i]; // [R4]
            end
         end
         assign chPinOe[i] = chEn[i] && !capMode && (chQ[i].edgeA || chQ[i].edgeB);
         assign chPinOut[i] = outQ[i];
         assign channelIrq[i] = chQ[i].flag && chQ[i].irqEn; // [R5]
      end
   endgenerate

   assign overflowIrq = ovfQ && ovieQ; // [R2]
   assign wakeReq = sysState.pwr == TCT_WAIT && (overflowIrq || |channelIrq); // [R20]
   assign portB3OutEnable = divQ == TCT_DIV_EXT ? 1'b0 : portB3DirectionBit; // [R12]

   // ==========================================================
   // Next-state logic
   always_comb
   begin
      ackD = busReq;
      rdatD = rdatQ;
      ovfD = ovfQ || ovfEvt;
      ovieD = ovieQ;
      haltD = haltQ;
      divD = divQ;
      cntD = cntQ;
      preD = preQ;
      latD = latQ;
      latdD = latdQ;
      modD = modQ;
      modLockD = modLockQ;
      ovfArmD = ovfArmQ && !ovfEvt; // [R6]
      extD = extCountClock;
      armD = armQ & ~chEvt; // [R7]
      pinD = chPinIn;
      outD = outQ;
      for (int i = 0; i < NCH; i++)
      begin
         chD[i] = chQ[i];
         cmpD[i] = cmpQ[i];
         if (chEvt[i])
            chD[i].flag = 1'b1;
         if (chEvt[i] && !(chQ[i].togOvf && ovfEvt)) // [R22]
            outD[i] = chQ[i].edgeB ? chQ[i].edgeA : (chQ[i].edgeA ? !outQ[i] : outQ[i]);
         if (ovfEvt && chQ[i].togOvf && !chQ[i].maxDuty)
            outD[i] = !outQ[i];
         if (chQ[i].modeA == 1'b0 && chEvt[i] && !chQ[i].bufSel && !chQ[i].flag)
            cmpD[i] = cntQ;
      end
      if (running)
      begin
         preD = preQ + 6'h01;
         if (tick)
            cntD = (cntQ == modQ) ? TCT_CNT_RST : cntQ + 16'h0001; // [R1]
      end
      if (rdEn)
      begin
         rdatD = TCT_RD_UNMAPPED;
         if (hit(adr, TCT_ADR_TSCTL))
         begin
            rdatD[7:0] = {ovfQ, ovieQ, haltQ, 1'b0, 1'b0, divQ}; // [R9]
            if (ovfQ && !brkProt)
               ovfArmD = 1'b1;
         end
         if (hit(adr, TCT_ADR_CNTH))
         begin
            rdatD[7:0] = cntQ[15:8];
            if (!latdQ) // [R13]
            begin
               latD = cntQ[7:0];
               latdD = 1'b1;
            end
         end
         if (hit(adr, TCT_ADR_CNTL))
         begin
            rdatD[7:0] = latdQ ? latQ : cntQ[7:0]; // [R13]
            latdD = 1'b0;
         end
         if (hit(adr, TCT_ADR_MODH))
            rdatD[7:0] = modQ[15:8];
         if (hit(adr, TCT_ADR_MODL))
            rdatD[7:0] = modQ[7:0];
         for (int i = 0; i < NCH; i++)
         begin
            if (hit(adr, TCT_ADR_CH0SC + 4'(3 * i)) && chEn[i])
            begin
               rdatD[7:0] = chQ[i];
               if (chQ[i].flag && !brkProt)
                  armD[i] = 1'b1;
            end
            if (hit(adr, TCT_ADR_CH0H + 4'(3 * i)))
               rdatD[7:0] = cmpQ[i][15:8];
            if (hit(adr, TCT_ADR_CH0L + 4'(3 * i)))
               rdatD[7:0] = cmpQ[i][7:0];
         end
      end
      if (wrEn)
      begin
         if (hit(adr, TCT_ADR_TSCTL))
         begin
            ovieD = wb_dat_i[TCT_B_OVIE];
            haltD = wb_dat_i[TCT_B_HALT]; // [R8]
            divD = wb_dat_i[2:0]; // [R11]
            if (!wb_dat_i[TCT_B_OVF] && ovfArmQ && !ovfEvt && !brkProt) // [R6] [R18] [R19]
            begin
               ovfD = 1'b0;
               ovfArmD = 1'b0;
            end
            if (wb_dat_i[TCT_B_CLR]) // [R9] [R10]
            begin
               cntD = TCT_CNT_RST;
               preD = TCT_PRE_RST;
            end
         end
         if (hit(adr, TCT_ADR_MODH))
         begin
            modD[15:8] = wb_dat_i[7:0];
            modLockD = 1'b1; // [R14]
         end
         if (hit(adr, TCT_ADR_MODL))
         begin
            modD[7:0] = wb_dat_i[7:0];
            modLockD = 1'b0; // [R14]
         end
         for (int i = 0; i < NCH; i++)
         begin
            if (hit(adr, TCT_ADR_CH0SC + 4'(3 * i)) && chEn[i]) // [R16]
            begin
               chD[i] = tct_chsc_t'(wb_dat_i[7:0]);
               chD[i].flag = chQ[i].flag || chEvt[i];
               if (i != 0)
                  chD[i].bufSel = 1'b0;
               if (!wb_dat_i[TCT_B_CHF] && armQ[i] && !chEvt[i] && !brkProt) // [R7] [R18]
               begin
                  chD[i].flag = 1'b0;
                  armD[i] = 1'b0;
               end
            end
            if (hit(adr, TCT_ADR_CH0H + 4'(3 * i)))
               cmpD[i][15:8] = wb_dat_i[7:0];
            if (hit(adr, TCT_ADR_CH0L + 4'(3 * i)))
               cmpD[i][7:0] = wb_dat_i[7:0];
         end
      end
   end

   // ==========================================================
   // State registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ackQ <= 1'b0;
         rdatQ <= 32'h0000_0000;
         ovfQ <= 1'b0;
         ovieQ <= 1'b0;
         haltQ <= 1'b1; // [R8]
         divQ <= TCT_DIV_RST;
         cntQ <= TCT_CNT_RST;
         preQ <= TCT_PRE_RST;
         latQ <= 8'h00;
         latdQ <= 1'b0;
         modQ <= TCT_MOD_RST; // [R14]
         modLockQ <= 1'b0;
         ovfArmQ <= 1'b0;
         extQ <= 1'b0;
         armQ <= '0;
         pinQ <= '0;
         outQ <= '0;
         for (int i = 0; i < NCH; i++)
         begin
            chQ[i] <= tct_chsc_t'(TCT_CHSC_RST); // [R5]
            cmpQ[i] <= 16'h0000;
         end
      end
      else
      begin
         ackQ <= ackD;
         rdatQ <= rdatD;
         ovfQ <= ovfD;
         ovieQ <= ovieD;
         haltQ <= haltD;
         divQ <= divD;
         cntQ <= cntD;
         preQ <= preD;
         latQ <= latD;
         latdQ <= latdD;
         modQ <= modD;
         modLockQ <= modLockD;
         ovfArmQ <= ovfArmD;
         extQ <= extD;
         armQ <= armD;
         pinQ <= pinD;
         outQ <= outD;
         for (int i = 0; i < NCH; i++)
         begin
            chQ[i] <= chD[i];
            cmpQ[i] <= cmpD[i];
         end
      end
   end
   assign wb_dat_o = rdatQ;

   // ==========================================================
   // Checks
   sequence s_clrWrite;
      wrEn && hit(adr, TCT_ADR_TSCTL) && wb_dat_i[TCT_B_CLR];
   endsequence
   property p_rollover;
      @(posedge mclk) disable iff (!rst_n) ovfEvt |=> cntQ == 16'h0000 && ovfQ;
   endproperty
   a_rollover: assert property (p_rollover) else $error("rollover missed"); // [R1]
   property p_ovfIrq;
      @(posedge mclk) disable iff (!rst_n) ovfEvt && ovieQ && !wrEn |=> overflowIrq;
   endproperty
   a_ovfIrq: assert property (p_ovfIrq) else $error("overflow irq wrong"); // [R2]
   property p_chFlag;
      @(posedge mclk) disable iff (!rst_n) chEvt[0] |=> chQ[0].flag;
   endproperty
   a_chFlag: assert property (p_chFlag) else $error("channel flag missed"); // [R3]
   property p_halt;
      @(posedge mclk) disable iff (!rst_n) haltQ && !wrEn |=> $stable(cntQ);
   endproperty
   a_halt: assert property (p_halt) else $error("halted counter moved"); // [R8]
   property p_clear;
      @(posedge mclk) disable iff (!rst_n) s_clrWrite |=> cntQ == 16'h0000 && preQ == 6'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed"); // [R9]
   property p_brk;
      @(posedge mclk) disable iff (!rst_n) sysState.brk && !wrEn |=> $stable(cntQ);
   endproperty
   a_brk: assert property (p_brk) else $error("counter moved in break"); // [R17]
   property p_lock;
      @(posedge mclk) disable iff (!rst_n) modLockQ |-> !ovfEvt;
   endproperty
   a_lock: assert property (p_lock) else $error("overflow while locked"); // [R14]
   property p_extPin;
      @(posedge mclk) disable iff (!rst_n) divQ == TCT_DIV_EXT |-> !portB3OutEnable;
   endproperty
   a_extPin: assert property (p_extPin) else $error("ext pin driven"); // [R12]
   property p_ovfSticky;
      @(posedge mclk) disable iff (!rst_n) ovfQ && !ovfArmQ |=> ovfQ;
   endproperty
   a_ovfSticky: assert property (p_ovfSticky) else $error("flag lost"); // [R6]
endmodule
`default_nettype wire

//--- sim/tct_pins_model.sv
// Far-side pin model: channel pins and the external count clock
// Assumes the bench asks for pin levels and clock activity on mclk
`timescale 1ns/1ps
`default_nettype none
module tct_pins_model
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [1:0] drive,
   input wire logic clkEn,
   output logic [1:0] chPin,
   output logic extClk
);
   // ==========================================
   // Pin levels and external clock
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chPin <= 2'h0;
         extClk <= 1'b0;
      end
      else
      begin
         chPin <= drive;
         // Half bus rate at most, still outside use
         extClk <= clkEn ? ~extClk : 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- sim/tb_two_channel_timer_core.sv
// Self-checking bench of the two-channel timer over classic Wishbone
// Assumes tct_pkg word map and a pin model on the channel and clock pins
`timescale 1ns/1ps
`default_nettype none
module tb_two_channel_timer_core;
   import tct_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] datI = 32'h0;
   logic [31:0] datO;
   logic ack, extClk, b3Oe, ovIrq, wake;
   tct_sys_t sys = '{1'b0, 1'b0, TCT_RUN};
   logic clkEn = 1'b0;
   logic [1:0] drive = 2'h0;
   logic [1:0] chPin, chOut, chOe, chIrq;
   int miscompares = 0;
   int checks = 0;
   int seed = 14129;
   int waited;
   logic [7:0] m [16];
   logic [7:0] rdat, v0;
   always #10 mclk = ~mclk;
   tct_pins_model pins_u (.mclk(mclk), .rst_n(rst_n), .drive(drive), .clkEn(clkEn),
      .chPin(chPin), .extClk(extClk));
   tct_timer #(.NCH(2)) dut_u (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(datI),
      .wb_dat_o(datO), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .sysState(sys), .extCountClock(extClk), .portB3DirectionBit(1'b1),
      .portB3OutEnable(b3Oe), .chPinIn(chPin), .chPinOut(chOut), .chPinOe(chOe),
      .overflowIrq(ovIrq), .channelIrq(chIrq), .wakeReq(wake));
   // ==========================================
   // Tasks
   task automatic test_done();
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      waited = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {26'h0, a, 2'h0};
      datI <= {24'h0, d};
      do
      begin
         @(posedge mclk);
         waited++;
      end
      while (ack !== 1'b1 && waited < 500);
      rdat = datO[7:0];
      if (waited >= 500)
      begin
         miscompares++;
         test_done();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      if (w)
         m[a] = d;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(rdat, e);
   endtask
   // ==========================================
   // Scenarios
   initial
   begin
      m[3] = TCT_MOD_RST[15:8];
      m[4] = TCT_MOD_RST[7:0];
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(TCT_ADR_TSCTL, 8'h20);
      rd(TCT_ADR_MODH, m[3]);
      rd(TCT_ADR_MODL, m[4]);
      rd(TCT_ADR_CH0SC, TCT_CHSC_RST);
      bus(1'b1, TCT_ADR_TSCTL, 8'h00);
      repeat (40) @(posedge mclk);
      bus(1'b1, TCT_ADR_TSCTL, 8'h20);
      bus(1'b0, TCT_ADR_CNTL, 8'h00);
      v0 = rdat;
      repeat (20) @(posedge mclk);
      rd(TCT_ADR_CNTL, v0);
      rd(TCT_ADR_TSCTL, 8'h20);
      bus(1'b1, TCT_ADR_TSCTL, 8'h30);
      rd(TCT_ADR_CNTH, 8'h00);
      bus(1'b1, TCT_ADR_TSCTL, 8'h00);
      repeat (30) @(posedge mclk);
      rd(TCT_ADR_CNTH, 8'h00);
      rd(TCT_ADR_CNTL, 8'h00);
      bus(1'b1, TCT_ADR_TSCTL, 8'h30);
      bus(1'b1, TCT_ADR_MODH, 8'h00);
      bus(1'b1, TCT_ADR_TSCTL, 8'h00);
      repeat (300) @(posedge mclk);
      rd(TCT_ADR_TSCTL, 8'h00);
      bus(1'b1, TCT_ADR_MODL, 8'h05);
      rd(TCT_ADR_MODH, m[3]);
      bus(1'b1, TCT_ADR_TSCTL, 8'h10);
      repeat (40) @(posedge mclk);
      bus(1'b1, TCT_ADR_TSCTL, 8'h20);
      rd(TCT_ADR_TSCTL, 8'hA0);
      chk({7'h0, ovIrq}, 8'h00);
      bus(1'b1, TCT_ADR_TSCTL, 8'hE0);
      chk({7'h0, ovIrq}, 8'h01);
      sys.pwr <= TCT_WAIT;
      @(posedge mclk);
      @(posedge mclk);
      chk({7'h0, wake}, 8'h01);
      fork
         bus(1'b0, TCT_ADR_TSCTL, 8'h00);
         begin
            repeat (20) @(posedge mclk);
            sys.pwr <= TCT_RUN;
         end
      join
      chk({7'h0, waited > 20}, 8'h01);
      chk(rdat, 8'hE0);
      sys.brk <= 1'b1;
      bus(1'b1, TCT_ADR_TSCTL, 8'h60);
      rd(TCT_ADR_TSCTL, 8'hE0);
      sys.brk <= 1'b0;
      bus(1'b1, TCT_ADR_TSCTL, 8'h60);
      rd(TCT_ADR_TSCTL, 8'h60);
      chk({7'h0, ovIrq}, 8'h00);
      v0 = 8'($random(seed));
      bus(1'b1, TCT_ADR_CH0H, v0);
      bus(1'b1, TCT_ADR_CH0L, ~v0);
      rd(TCT_ADR_CH0H, m[6]);
      rd(TCT_ADR_CH0L, m[7]);
      bus(1'b1, TCT_ADR_CH0SC, 8'h04);
      drive <= 2'h1;
      repeat (4) @(posedge mclk);
      chk({6'h0, chIrq}, 8'h00);
      rd(TCT_ADR_CH0SC, 8'h84);
      bus(1'b1, TCT_ADR_CH0SC, 8'hC4);
      chk({6'h0, chIrq}, 8'h01);
      rd(TCT_ADR_CH0SC, 8'hC4);
      sys <= '{1'b1, 1'b1, TCT_RUN};
      bus(1'b1, TCT_ADR_CH0SC, 8'h44);
      sys <= '{1'b0, 1'b0, TCT_RUN};
      rd(TCT_ADR_CH0SC, 8'h44);
      bus(1'b1, TCT_ADR_CH0SC, 8'h20);
      bus(1'b1, TCT_ADR_CH1SC, 8'h44);
      rd(TCT_ADR_CH1SC, 8'h00);
      bus(1'b1, TCT_ADR_TSCTL, 8'h30);
      bus(1'b1, TCT_ADR_CH0H, 8'h00);
      bus(1'b1, TCT_ADR_CH0L, 8'h03);
      bus(1'b1, TCT_ADR_CH0SC, 8'h14);
      bus(1'b1, TCT_ADR_TSCTL, 8'h00);
      repeat (3) @(posedge mclk);
      bus(1'b1, TCT_ADR_TSCTL, 8'h20);
      rd(TCT_ADR_CH0SC, 8'h94);
      chk({7'h0, chOe[0]}, 8'h01);
      bus(1'b1, TCT_ADR_TSCTL, 8'h17);
      clkEn <= 1'b1;
      repeat (20) @(posedge mclk);
      chk({7'h0, b3Oe}, 8'h00);
      bus(1'b1, TCT_ADR_TSCTL, 8'h20);
      clkEn <= 1'b0;
      chk({7'h0, b3Oe}, 8'h01);
      sys.brk <= 1'b1;
      bus(1'b1, TCT_ADR_TSCTL, 8'h00);
      bus(1'b0, TCT_ADR_CNTL, 8'h00);
      v0 = rdat;
      repeat (10) @(posedge mclk);
      rd(TCT_ADR_CNTL, v0);
      test_done();
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      test_done();
   end
endmodule
`default_nettype wire
